/* File: core/link_status_regs.sv */
// link status register bank with ahb-lite slave
// How it works
// - current speed is four bits, resets to 1; 1 is 2.5 GT/s, 2 is 5 GT/s.
// - negotiated width uses codes x1,x2,x4,x12,x16,x32 in bits 9:4.
// - unsupported max width setting makes the width field mirror that setting.
// - supported max width but failed training reports width zero.
// - width reporting uses function 0 max width setting only.
// - slot clock bit set means common reference clock with the partner.
// - slot clock bit initialised from clocking mode, write-lockable, sticky.
// - every function reads the same slot clock bit.
// - bits 10, 11, 13, 14 and 15 always read zero.
module link_status_regs #(
  parameter logic [5:0] SUPPORTED = link_status_pkg::SUPPORTED_MASK
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        soft_reset,
  input  wire logic [3:0]  link_speed,
  input  wire logic [5:0]  trained_width,
  input  wire logic        link_trained,
  input  wire logic        clock_mode
);
  // ==========================================================
  // bus state
  typedef enum logic [1:0] {
    bus_idle,
    bus_write,
    bus_read1,
    bus_read2
  } bus_state_t;

  bus_state_t  state;
  bus_state_t  next_state;
  logic [9:0]  idx;
  logic        take;
  logic [31:0] next_rdata;
  logic        wr_status;
  logic        wr_ctrl;
  logic        wr_maxw0;
  logic        wr_maxw1;

  // ==========================================================
  // block state
  logic [3:0]  speed;
  logic [5:0]  maxw0;
  logic [5:0]  maxw1;
  logic        multi_func;
  logic        locked;
  logic        func_sel;
  logic        slot_clock;
  logic [5:0]  width_field;
  logic [15:0] status_word;

  assign hresp = 1'b0;
  assign take  = hsel && hready && htrans[1];
  assign hreadyout = (state != bus_read1);

  // ==========================================================
  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx <= 10'h000;
    end else if (take) begin
      idx <= haddr[link_status_pkg::ADDR_MSB:link_status_pkg::ADDR_LSB];
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      bus_read1: begin
        next_state = bus_read2;
      end
      default: begin
        if (take && hwrite) begin
          next_state = bus_write;
        end else if (take) begin
          next_state = bus_read1;
        end else if (hready) begin
          next_state = bus_idle;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= bus_idle;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // write decode in the data phase
  always_comb begin
    wr_status = 1'b0;
    wr_ctrl   = 1'b0;
    wr_maxw0  = 1'b0;
    wr_maxw1  = 1'b0;
    if (state == bus_write) begin
      if (idx == link_status_pkg::STATUS_IDX) begin
        wr_status = 1'b1;
      end else if (idx == link_status_pkg::CTRL_IDX) begin
        wr_ctrl = 1'b1;
      end else if (idx == link_status_pkg::MAXW0_IDX) begin
        wr_maxw0 = 1'b1;
      end else if (idx == link_status_pkg::MAXW1_IDX) begin
        wr_maxw1 = 1'b1;
      end
    end
  end

  // ==========================================================
  // control and max width settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      multi_func <= 1'b0;
      locked     <= 1'b0;
      func_sel   <= 1'b0;
    end else if (soft_reset) begin
      multi_func <= 1'b0;
      locked     <= 1'b0;
      func_sel   <= 1'b0;
    end else if (wr_ctrl) begin
      multi_func <= hwdata[link_status_pkg::CTRL_MULTI_BIT];
      locked     <= hwdata[link_status_pkg::CTRL_LOCK_BIT];
      func_sel   <= hwdata[link_status_pkg::CTRL_FSEL_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      maxw0 <= link_status_pkg::MAXW_RESET;
      maxw1 <= link_status_pkg::MAXW_RESET;
    end else if (soft_reset) begin
      maxw0 <= link_status_pkg::MAXW_RESET;
      maxw1 <= link_status_pkg::MAXW_RESET;
    end else begin
      if (wr_maxw0) begin
        maxw0 <= hwdata[5:0];
      end
      if (wr_maxw1) begin
        maxw1 <= hwdata[5:0];
      end
    end
  end

  // ==========================================================
  // current speed follows the training logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed <= link_status_pkg::SPEED_RESET;
    end else if (soft_reset) begin
      speed <= link_status_pkg::SPEED_RESET;
    end else begin
      speed <= link_speed;
    end
  end

  // ==========================================================
  // width and slot clock
  // function 0 setting drives the width in every mode
  width_reporter #(
    .SUPPORTED     (SUPPORTED)
  ) u_width (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .soft_reset    (soft_reset),
    .max_width     (maxw0),
    .trained_width (trained_width),
    .link_trained  (link_trained),
    .width_field   (width_field)
  );

  slot_clock_bit u_sclk (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .clock_mode (clock_mode),
    .wr_en      (wr_status),
    .wr_value   (hwdata[link_status_pkg::SCLK_BIT]),
    .locked     (locked),
    .slot_clock (slot_clock)
  );

  // one word serves both functions
  always_comb begin
    status_word = '0;
    status_word[link_status_pkg::SPEED_LSB +: 4] = speed;
    status_word[link_status_pkg::WIDTH_LSB +: 6] = width_field;
    status_word[link_status_pkg::SCLK_BIT] = slot_clock;
  end

  // ==========================================================
  // read data, loaded in the wait cycle
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (idx == link_status_pkg::STATUS_IDX) begin
      next_rdata[15:0] = status_word;
    end else if (idx == link_status_pkg::CTRL_IDX) begin
      next_rdata[link_status_pkg::CTRL_MULTI_BIT] = multi_func;
      next_rdata[link_status_pkg::CTRL_LOCK_BIT]  = locked;
      next_rdata[link_status_pkg::CTRL_FSEL_BIT]  = func_sel;
    end else if (idx == link_status_pkg::MAXW0_IDX) begin
      next_rdata[5:0] = maxw0;
    end else if (idx == link_status_pkg::MAXW1_IDX) begin
      next_rdata[5:0] = maxw1;
    end else if (idx == link_status_pkg::RAW_IDX) begin
      next_rdata[3:0] = link_speed;
      next_rdata[9:4] = trained_width;
      next_rdata[link_status_pkg::RAW_TRAIN_BIT] = link_trained;
      next_rdata[link_status_pkg::RAW_MODE_BIT]  = clock_mode;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (state == bus_read1) begin
      hrdata <= next_rdata;
    end
  end

  // ==========================================================
  // checks
  chk_speed_reset_one: assert property (
    @(posedge hclk) $rose(hresetn) |-> speed == 4'h1)
    else $error("speed field not one after reset");

  chk_speed_follows: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !soft_reset |=> speed == $past(link_speed))
    else $error("speed field does not follow link");

  chk_width_mirror: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!soft_reset && maxw0 != 6'h01 && maxw0 != 6'h02 && maxw0 != 6'h04
      && SUPPORTED == 6'h07) |=> width_field == $past(maxw0))
    else $error("width does not mirror unsupported setting");

  chk_width_fail_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!soft_reset && !link_trained && maxw0 == 6'h04 && SUPPORTED[2])
      |=> width_field == 6'h00)
    else $error("width not zero on failed training");

  chk_width_trained: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!soft_reset && link_trained && maxw0 == 6'h01 && SUPPORTED[0])
      |=> width_field == $past(trained_width))
    else $error("width does not show trained width");

  chk_func1_ignored: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_maxw1 && !soft_reset) |=> $stable(maxw0))
    else $error("function 1 setting reached function 0");

  chk_sclk_init: assert property (
    @(posedge hclk) $rose(hresetn) |=> slot_clock == $past(clock_mode))
    else $error("slot clock bit not taken from clock mode");

  chk_sclk_locked: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (u_sclk.captured && locked) |=> $stable(slot_clock))
    else $error("slot clock bit changed while locked");

  chk_sclk_sticky: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (u_sclk.captured && soft_reset && !wr_status) |=> $stable(slot_clock))
    else $error("slot clock bit lost on soft reset");

  chk_reserved_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (state == bus_read2 && idx == link_status_pkg::STATUS_IDX)
      |-> (hrdata[31:13] == 19'h0 && hrdata[11:10] == 2'h0
           && hrdata[12] == $past(slot_clock)))
    else $error("status reserved bits not zero");

  chk_ro_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_status && !soft_reset) |=> speed == $past(link_speed))
    else $error("status write altered read-only field");

  chk_speed_soft_reset: assert property (
    @(posedge hclk) disable iff (!hresetn)
    soft_reset |=> speed == link_status_pkg::SPEED_RESET)
    else $error("speed field not one after soft reset");

  chk_sclk_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (u_sclk.captured && wr_status && !locked)
      |=> slot_clock == $past(hwdata[link_status_pkg::SCLK_BIT]))
    else $error("unlocked slot clock write not taken");

  chk_width_x12_mirror: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!soft_reset && maxw0 == link_status_pkg::WIDTH_X12B)
      |=> width_field == link_status_pkg::WIDTH_X12B)
    else $error("width does not mirror x12 setting");
endmodule

/* File: core/link_status_pkg.sv */
// constants for the link status register bank
package link_status_pkg;
  // ==========================================================
  // register indices (byte address = index * 4)
  localparam logic [9:0]  STATUS_IDX     = 10'h052;
  localparam logic [9:0]  CTRL_IDX       = 10'h0f0;
  localparam logic [9:0]  MAXW0_IDX      = 10'h0f1;
  localparam logic [9:0]  MAXW1_IDX      = 10'h0f2;
  localparam logic [9:0]  RAW_IDX        = 10'h0f3;
  localparam int          ADDR_LSB       = 2;
  localparam int          ADDR_MSB       = 11;
  // ==========================================================
  // status word fields
  localparam int          SPEED_LSB      = 0;
  localparam int          SPEED_W        = 4;
  localparam int          WIDTH_LSB      = 4;
  localparam int          WIDTH_W        = 6;
  localparam int          SCLK_BIT       = 12;
  localparam int          STATUS_W       = 16;
  // ==========================================================
  // control register fields
  localparam int          CTRL_MULTI_BIT = 0;
  localparam int          CTRL_LOCK_BIT  = 1;
  localparam int          CTRL_FSEL_BIT  = 2;
  // raw register fields
  localparam int          RAW_TRAIN_BIT  = 10;
  localparam int          RAW_MODE_BIT   = 11;
  // ==========================================================
  // reset values and codes
  localparam logic [3:0]  SPEED_RESET    = 4'h1;
  localparam logic [3:0]  SPEED_GEN1     = 4'h1;
  localparam logic [3:0]  SPEED_GEN2     = 4'h2;
  localparam logic [5:0]  MAXW_RESET     = 6'h04;
  localparam logic [5:0]  WIDTH_FAIL     = 6'h00;
  localparam logic [5:0]  WIDTH_X1       = 6'h01;
  localparam logic [5:0]  WIDTH_X2       = 6'h02;
  localparam logic [5:0]  WIDTH_X4       = 6'h04;
  localparam logic [5:0]  WIDTH_X12A     = 6'h08;
  localparam logic [5:0]  WIDTH_X12B     = 6'h18;
  localparam logic [5:0]  WIDTH_X16      = 6'h10;
  localparam logic [5:0]  WIDTH_X32      = 6'h20;
  localparam logic [5:0]  SUPPORTED_MASK = 6'h07;
endpackage

/* File: core/width_reporter.sv */
// negotiated width reporting from max width setting and training result
module width_reporter #(
  parameter logic [5:0] SUPPORTED = link_status_pkg::SUPPORTED_MASK
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       soft_reset,
  input  wire logic [5:0] max_width,
  input  wire logic [5:0] trained_width,
  input  wire logic       link_trained,
  output logic      [5:0] width_field
);
  // ==========================================================
  // supported check, one term per one-hot width code
  logic [5:0] hit;
  logic       supported;
  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_hit
      assign hit[i] = SUPPORTED[i] && (max_width == (6'h01 << i));
    end
  endgenerate
  assign supported = |hit;

  // ==========================================================
  // registered field
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      width_field <= link_status_pkg::WIDTH_FAIL;
    end else if (soft_reset) begin
      width_field <= link_status_pkg::WIDTH_FAIL;
    end else if (!supported) begin
      width_field <= max_width;
    end else if (!link_trained) begin
      width_field <= link_status_pkg::WIDTH_FAIL;
    end else begin
      width_field <= trained_width;
    end
  end
endmodule

/* File: core/slot_clock_bit.sv */
// sticky, write-lockable slot clock configuration bit
module slot_clock_bit (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic clock_mode,
  input  wire logic wr_en,
  input  wire logic wr_value,
  input  wire logic locked,
  output logic      slot_clock
);
  logic captured;

  // ==========================================================
  // strap taken on the first edge after reset release
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      captured <= 1'b0;
    end else begin
      captured <= 1'b1;
    end
  end

  // soft reset does not reach this bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_clock <= 1'b0;
    end else if (!captured) begin
      slot_clock <= clock_mode;
    end else if (wr_en && !locked) begin
      slot_clock <= wr_value;
    end
  end
endmodule

/* File: tb/link_partner_model.sv */
// behavioural link training logic feeding the status bank
module link_partner_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [3:0] want_speed,
  input  wire logic [5:0] want_width,
  input  wire logic       want_ok,
  input  wire logic       retrain,
  input  wire logic [3:0] train_cyc,
  output logic      [3:0] link_speed,
  output logic      [5:0] trained_width,
  output logic            link_trained,
  output logic            settled
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  // ==========================================================
  // training: width wobbles until settled, trained flag only at end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
      link_speed <= 4'h1;
      trained_width <= 6'h00;
      link_trained <= 1'b0;
      settled <= 1'b0;
    end else if (retrain) begin
      cnt <= train_cyc;
      link_trained <= 1'b0;
      settled <= 1'b0;
      trained_width <= ~trained_width;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      trained_width <= ~trained_width;
    end else begin
      link_speed <= want_speed;
      trained_width <= want_width;
      link_trained <= want_ok;
      settled <= 1'b1;
    end
  end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the link status register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_STS = 32'(link_status_pkg::STATUS_IDX) << 2;
  localparam logic [31:0] A_CTL = 32'(link_status_pkg::CTRL_IDX) << 2;
  localparam logic [31:0] A_MW0 = 32'(link_status_pkg::MAXW0_IDX) << 2;
  localparam logic [31:0] A_MW1 = 32'(link_status_pkg::MAXW1_IDX) << 2;
  localparam logic [31:0] A_RAW = 32'(link_status_pkg::RAW_IDX) << 2;
  localparam logic [31:0] A_UNM = 32'h0000_0100;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, soft_reset;
  logic        link_trained, clock_mode, want_ok, retrain, settled;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  link_speed, want_speed, train_cyc;
  logic [5:0]  trained_width, want_width, mw;
  logic        exp_sclk;
  int          bad_count, n_compared, seed;
  logic [5:0]  codes [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h18, 6'h10, 6'h20, 6'h00};

  link_status_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .soft_reset(soft_reset),
    .link_speed(link_speed), .trained_width(trained_width), .link_trained(link_trained),
    .clock_mode(clock_mode));
  link_partner_model partner (.hclk(hclk), .hresetn(hresetn), .want_speed(want_speed),
    .want_width(want_width), .want_ok(want_ok), .retrain(retrain), .train_cyc(train_cyc),
    .link_speed(link_speed), .trained_width(trained_width), .link_trained(link_trained),
    .settled(settled));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // ==========================================================
  // checking and reporting
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] exp_sts(logic [5:0] m);
    logic [5:0] w;
    if (!(m inside {6'h01, 6'h02, 6'h04})) w = m;
    else if (!want_ok) w = 6'h00;
    else w = want_width;
    return {16'h0, 3'b000, exp_sclk, 2'b00, w, want_speed};
  endfunction
  // ==========================================================
  // ahb-lite single word transfer, waits on hready both phases
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    htrans <= 2'b00;
    hwdata <= d;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic train(input logic [3:0] cyc);
    int n;
    train_cyc <= cyc;
    retrain <= 1'b1;
    @(posedge hclk);
    retrain <= 1'b0;
    @(posedge hclk);
    n = 0;
    while (settled !== 1'b1 && n < 50) begin @(posedge hclk); n++; end
    chk("settled", 32'h1, {31'h0, settled});
    repeat (2) @(posedge hclk);
  endtask

  task automatic do_reset(input logic m);
    hresetn <= 1'b0;
    clock_mode <= m;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    exp_sclk = m;
    bus(0, A_CTL, 32'h0);
    chk("ctrl", 32'h0, q);
    bus(0, A_MW0, 32'h0);
    chk("maxw0", 32'h4, q);
    train(4'h3);
    bus(0, A_STS, 32'h0);
    chk("status", exp_sts(6'h04), q);
  endtask

  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
  // ==========================================================
  // main sequence
  initial begin
    {hsel, hwrite, soft_reset, retrain, want_ok} = '0;
    {haddr, hwdata, htrans, hsize, train_cyc} = '0;
    hsize = 3'b010;
    want_speed = 4'h1;
    want_width = 6'h01;
    seed = 72561;
    hresetn = 1'b0;
    clock_mode = 1'b0;
    do_reset(1'b0);
    for (int i = 0; i < 24; i++) begin
      want_speed <= (i < 2) ? 4'(i + 1) : 4'($random(seed));
      want_width <= codes[$unsigned($random(seed)) % 8];
      want_ok <= 1'($random(seed));
      mw = (i % 3 == 0) ? 6'($random(seed)) : codes[$unsigned($random(seed)) % 8];
      bus(1, A_CTL, {29'h0, 1'($random(seed)), 2'b01});
      bus(1, A_MW0, {26'h0, mw});
      bus(1, A_MW1, {26'h0, mw});
      train(4'($random(seed)));
      bus(0, A_STS, 32'h0);
      chk("status", exp_sts(mw), q);
    end
    bus(1, A_MW0, 32'h4);
    bus(1, A_MW1, 32'h20);
    bus(0, A_STS, 32'h0);
    chk("status", exp_sts(6'h04), q);
    bus(0, A_MW1, 32'h0);
    chk("maxw1", 32'h20, q);
    bus(0, A_RAW, 32'h0);
    chk("raw", {20'h0, clock_mode, want_ok, want_width, want_speed}, q);
    bus(1, A_STS, 32'hffff_ffff);
    exp_sclk = 1'b1;
    bus(0, A_STS, 32'h0);
    chk("status", exp_sts(6'h04), q);
    bus(1, A_CTL, 32'h2);
    bus(1, A_STS, 32'h0);
    bus(0, A_STS, 32'h0);
    chk("status", exp_sts(6'h04), q);
    soft_reset <= 1'b1;
    @(posedge hclk);
    soft_reset <= 1'b0;
    repeat (2) @(posedge hclk);
    bus(0, A_MW0, 32'h0);
    chk("maxw0", 32'h4, q);
    bus(0, A_STS, 32'h0);
    chk("status", exp_sts(6'h04), q);
    bus(1, A_STS, 32'h0);
    exp_sclk = 1'b0;
    bus(0, A_STS, 32'h0);
    chk("status", exp_sts(6'h04), q);
    bus(1, A_UNM, 32'hffff_ffff);
    bus(0, A_UNM, 32'h0);
    chk("unmapped", 32'h0, q);
    do_reset(1'b1);
    report_and_stop();
  end
endmodule
